/* File: rtl/iev_pkg.sv */
package iev_pkg;
  // ----------------------------------------
  // register addresses and reset values
  // ----------------------------------------
  localparam logic [7:0] ADDR_TIMER_IRQ_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'ha8;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY = 8'hb8;
  localparam logic [7:0] RST_TIMER_IRQ_CONTROL = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_PRIORITY = 8'h00;
  // unimplemented bits always read zero
  localparam logic [7:0] EN_IMPL_MASK = 8'hbf;
  localparam logic [7:0] PRI_IMPL_MASK = 8'h3f;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_GLOBAL_IRQ_GATE = 7;
  localparam int BIT_TIMER1_OVERFLOW_FLAG = 7;
  localparam int BIT_TIMER1_RUN = 6;
  localparam int BIT_TIMER0_OVERFLOW_FLAG = 5;
  localparam int BIT_TIMER0_RUN = 4;
  localparam int BIT_EXT1_REQUEST_FLAG = 3;
  localparam int BIT_EXT1_TRIGGER_TYPE = 2;
  localparam int BIT_EXT0_REQUEST_FLAG = 1;
  localparam int BIT_EXT0_TRIGGER_TYPE = 0;

  // ----------------------------------------
  // sources: index equals enable and priority bit, low index wins within a priority level
  // ----------------------------------------
  localparam int NUM_SRC = 6;
  localparam logic [2:0] SRC_EXT0 = 3'h0;
  localparam logic [2:0] SRC_TIMER0 = 3'h1;
  localparam logic [2:0] SRC_EXT1 = 3'h2;
  localparam logic [2:0] SRC_TIMER1 = 3'h3;
  localparam logic [2:0] SRC_SERIAL = 3'h4;
  localparam logic [2:0] SRC_TIMER2 = 3'h5;

  localparam logic [15:0] VEC_EXT0 = 16'h0003;
  localparam logic [15:0] VEC_TIMER0 = 16'h000b;
  localparam logic [15:0] VEC_EXT1 = 16'h0013;
  localparam logic [15:0] VEC_TIMER1 = 16'h001b;
  localparam logic [15:0] VEC_SERIAL = 16'h0023;
  localparam logic [15:0] VEC_TIMER2 = 16'h002b;

  localparam logic TRIG_LEVEL = 1'b0;
endpackage : iev_pkg

/* File: rtl/iev_pin_sync.sv */
`timescale 1ns/1ps
module iev_pin_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic pinRaw_n,
  output logic pinLow,
  output logic pinFall
);
  logic meta;
  logic stable;
  logic stableOld;

  // ----------------------------------------
  // two-stage synchroniser, edge seen after it
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta <= 1'b1;
      stable <= 1'b1;
      stableOld <= 1'b1;
    end else if (ce) begin
      meta <= pinRaw_n;
      stable <= meta;
      stableOld <= stable;
    end
  end

  assign pinLow = ~stable;
  assign pinFall = stableOld & ~stable;
endmodule : iev_pin_sync

/* File: rtl/iev_intc.sv */
`timescale 1ns/1ps
module iev_intc (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic extIrqPinA_n,
  input wire logic extIrqPinB_n,
  input wire logic timer0Overflow,
  input wire logic timer1Overflow,
  input wire logic timer2Pending,
  input wire logic serialPending,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData,
  output logic sfrRdHit,
  output logic timer0Run,
  output logic timer1Run,
  output logic irqReq,
  output logic [2:0] irqSrc,
  output logic [15:0] irqVector,
  input wire logic irqAck,
  input wire logic irqReturn
);
  logic [7:0] interruptEnable;
  logic [7:0] interruptPriority;
  logic ext0TriggerType;
  logic ext1TriggerType;
  logic ext0RequestFlag;
  logic ext1RequestFlag;
  logic timer0OverflowFlag;
  logic timer1OverflowFlag;
  logic activeHigh;
  logic activeLow;
  logic pinALow;
  logic pinAFall;
  logic pinBLow;
  logic pinBFall;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [2:0] firstSet(input logic [5:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = iev_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : firstSet

  function automatic logic [15:0] vecOf(input logic [2:0] src);
    case (src)
      iev_pkg::SRC_EXT0: vecOf = iev_pkg::VEC_EXT0;
      iev_pkg::SRC_TIMER0: vecOf = iev_pkg::VEC_TIMER0;
      iev_pkg::SRC_EXT1: vecOf = iev_pkg::VEC_EXT1;
      iev_pkg::SRC_TIMER1: vecOf = iev_pkg::VEC_TIMER1;
      iev_pkg::SRC_SERIAL: vecOf = iev_pkg::VEC_SERIAL;
      default: vecOf = iev_pkg::VEC_TIMER2;
    endcase
  endfunction : vecOf

  function automatic logic [5:0] lowerMask(input logic [2:0] src);
    return 6'((7'h01 << src) - 7'h01);
  endfunction : lowerMask

  // ----------------------------------------
  // external pins
  // ----------------------------------------
  iev_pin_sync u_syncA (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pinRaw_n(extIrqPinA_n),
    .pinLow(pinALow),
    .pinFall(pinAFall)
  );

  iev_pin_sync u_syncB (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .pinRaw_n(extIrqPinB_n),
    .pinLow(pinBLow),
    .pinFall(pinBFall)
  );

  // ----------------------------------------
  // decode and arbitration
  // ----------------------------------------
  wire wrCtl = sfrWrEn && (sfrAddr == iev_pkg::ADDR_TIMER_IRQ_CONTROL);
  wire wrEn = sfrWrEn && (sfrAddr == iev_pkg::ADDR_INTERRUPT_ENABLE);
  wire wrPri = sfrWrEn && (sfrAddr == iev_pkg::ADDR_INTERRUPT_PRIORITY);
  wire ackTake = irqAck && irqReq;
  wire ackExt0 = ackTake && (irqSrc == iev_pkg::SRC_EXT0);
  wire ackExt1 = ackTake && (irqSrc == iev_pkg::SRC_EXT1);
  wire ackT0 = ackTake && (irqSrc == iev_pkg::SRC_TIMER0);
  wire ackT1 = ackTake && (irqSrc == iev_pkg::SRC_TIMER1);

  wire [7:0] ctlView = {timer1OverflowFlag, timer1Run, timer0OverflowFlag, timer0Run,
                         ext1RequestFlag, ext1TriggerType, ext0RequestFlag, ext0TriggerType};
  wire [5:0] pendVec = {timer2Pending, serialPending, timer1OverflowFlag,
                        ext1RequestFlag, timer0OverflowFlag, ext0RequestFlag};
  wire globalIrqGate = interruptEnable[iev_pkg::BIT_GLOBAL_IRQ_GATE];
  wire [5:0] enVec = interruptEnable[5:0] & {6{globalIrqGate}};
  wire [5:0] candVec = pendVec & enVec;
  // a running high routine blocks all; a running low one blocks low
  wire [5:0] hiCand = candVec & interruptPriority[5:0] & {6{~activeHigh}};
  wire [5:0] loCand = candVec & ~interruptPriority[5:0] & {6{~activeHigh & ~activeLow}};
  wire [5:0] pickVec = (|hiCand) ? hiCand : loCand;
  wire [2:0] pickIdx = firstSet(pickVec);

  wire [7:0] rdMux = (sfrAddr == iev_pkg::ADDR_TIMER_IRQ_CONTROL) ? ctlView :
                     (sfrAddr == iev_pkg::ADDR_INTERRUPT_ENABLE) ?
                       (interruptEnable & iev_pkg::EN_IMPL_MASK) :
                     (sfrAddr == iev_pkg::ADDR_INTERRUPT_PRIORITY) ?
                       (interruptPriority & iev_pkg::PRI_IMPL_MASK) : 8'h00;
  wire rdMapped = (sfrAddr == iev_pkg::ADDR_TIMER_IRQ_CONTROL) ||
                  (sfrAddr == iev_pkg::ADDR_INTERRUPT_ENABLE) ||
                  (sfrAddr == iev_pkg::ADDR_INTERRUPT_PRIORITY);

  // ----------------------------------------
  // external and timer request flags
  // ----------------------------------------
  // level mode mirrors the pin; edge mode is sticky, set beats clear
  wire next_ext0Flag = (ext0TriggerType == iev_pkg::TRIG_LEVEL) ? pinALow :
                       (pinAFall || (!ackExt0 && (wrCtl ?
                        sfrWrData[iev_pkg::BIT_EXT0_REQUEST_FLAG] : ext0RequestFlag)));
  wire next_ext1Flag = (ext1TriggerType == iev_pkg::TRIG_LEVEL) ? pinBLow :
                       (pinBFall || (!ackExt1 && (wrCtl ?
                        sfrWrData[iev_pkg::BIT_EXT1_REQUEST_FLAG] : ext1RequestFlag)));
  wire next_t0Flag = timer0Overflow || (!ackT0 && (wrCtl ?
                     sfrWrData[iev_pkg::BIT_TIMER0_OVERFLOW_FLAG] : timer0OverflowFlag));
  wire next_t1Flag = timer1Overflow || (!ackT1 && (wrCtl ?
                     sfrWrData[iev_pkg::BIT_TIMER1_OVERFLOW_FLAG] : timer1OverflowFlag));

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      interruptEnable <= iev_pkg::RST_INTERRUPT_ENABLE;
      interruptPriority <= iev_pkg::RST_INTERRUPT_PRIORITY;
      {timer1OverflowFlag, timer1Run, timer0OverflowFlag, timer0Run, ext1RequestFlag,
       ext1TriggerType, ext0RequestFlag, ext0TriggerType} <= iev_pkg::RST_TIMER_IRQ_CONTROL;
    end else if (ce) begin
      if (wrEn) begin
        interruptEnable <= sfrWrData & iev_pkg::EN_IMPL_MASK;
      end
      if (wrPri) begin
        interruptPriority <= sfrWrData & iev_pkg::PRI_IMPL_MASK;
      end
      if (wrCtl) begin
        timer1Run <= sfrWrData[iev_pkg::BIT_TIMER1_RUN];
        timer0Run <= sfrWrData[iev_pkg::BIT_TIMER0_RUN];
        ext1TriggerType <= sfrWrData[iev_pkg::BIT_EXT1_TRIGGER_TYPE];
        ext0TriggerType <= sfrWrData[iev_pkg::BIT_EXT0_TRIGGER_TYPE];
      end
      ext0RequestFlag <= next_ext0Flag;
      ext1RequestFlag <= next_ext1Flag;
      timer0OverflowFlag <= next_t0Flag;
      timer1OverflowFlag <= next_t1Flag;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sfrRdData <= 8'h00;
      sfrRdHit <= 1'b0;
    end else if (ce) begin
      sfrRdData <= sfrRdEn ? rdMux : 8'h00;
      sfrRdHit <= sfrRdEn && rdMapped;
    end
  end

  // ----------------------------------------
  // request offer and in-service levels
  // ----------------------------------------
  // offer drops for one cycle after an ack so the new level is seen first
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqReq <= 1'b0;
      irqSrc <= iev_pkg::SRC_EXT0;
      irqVector <= iev_pkg::VEC_EXT0;
    end else if (ce) begin
      irqReq <= (|pickVec) && !ackTake;
      irqSrc <= pickIdx;
      irqVector <= vecOf(pickIdx);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      activeHigh <= 1'b0;
      activeLow <= 1'b0;
    end else if (ce) begin
      if (ackTake && interruptPriority[irqSrc]) begin
        activeHigh <= 1'b1;
      end else if (irqReturn && activeHigh) begin
        activeHigh <= 1'b0;
      end
      if (ackTake && !interruptPriority[irqSrc]) begin
        activeLow <= 1'b1;
      end else if (irqReturn && !activeHigh) begin
        activeLow <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_ackTimer0;
    ce && ackT0 && !timer0Overflow && !wrCtl;
  endsequence
  sequence s_ackTimer1;
    ce && ackT1 && !timer1Overflow && !wrCtl;
  endsequence

  AST_GATE_CLOSED: assert property ((ce && !globalIrqGate) |=> !irqReq)
    else $error("request offered with global gate closed");
  // index the previous enables with the source offered now, not the one offered before
  AST_ENABLE_HELD: assert property (($past(ce) && irqReq) |->
    ((($past(enVec) >> irqSrc) & 6'h01) != 6'h00))
    else $error("request offered for a disabled source");
  AST_EN_RESERVED: assert property (interruptEnable[6] == 1'b0)
    else $error("unimplemented enable bit holds a one");
  AST_VECTOR_MAP: assert property (irqReq |-> irqVector == vecOf(irqSrc))
    else $error("vector does not match source");
  AST_LEVEL_TRIG: assert property ((ce && !ext0TriggerType && !wrCtl) |=>
    (ext0RequestFlag == $past(pinALow)))
    else $error("level trigger flag does not follow pin");
  AST_TIE_ORDER: assert property (($past(ce) && irqReq) |->
    (($past(pickVec) & lowerMask(irqSrc)) == 6'h00))
    else $error("lower ranked source won a tie");
  AST_NO_PREEMPT: assert property (irqReq |-> (!activeHigh &&
    (!activeLow || interruptPriority[irqSrc])))
    else $error("request offered that would preempt a running routine");
  AST_T0_CLEAR: assert property (s_ackTimer0 |=> !timer0OverflowFlag)
    else $error("timer0 flag survived its acknowledge");
  AST_T1_CLEAR: assert property (s_ackTimer1 |=> !timer1OverflowFlag)
    else $error("timer1 flag survived its acknowledge");
  AST_ACK_DROP: assert property ((ce && ackTake) |=> !irqReq ##1 1'b1)
    else $error("offer did not drop after acknowledge");
endmodule : iev_intc

/* File: dv/iev_core_model.sv */
`timescale 1ns/1ps
module iev_core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic irqReq,
  input wire logic [2:0] irqSrc,
  input wire logic [15:0] irqVector,
  input wire logic acking,
  input wire logic [3:0] ackDelay,
  input wire logic [7:0] svcLen,
  output logic irqAck,
  output logic irqReturn,
  output logic took,
  output logic [2:0] tookSrc,
  output logic [15:0] tookVec
);
  // ----
  // core side: takes offers, nests routines
  // ----
  int wt;
  int gap;
  int cnt[$];
  always @(posedge clk) begin
    irqAck <= 1'b0;
    irqReturn <= 1'b0;
    took <= irqAck;
    tookSrc <= irqSrc;
    tookVec <= irqVector;
    if (sys_rst) begin
      wt = 0;
      gap = 0;
      cnt.delete();
    end else begin
      if (cnt.size() > 0) begin
        cnt[$] = cnt[$] - 1;
        if (cnt[$] <= 0) begin
          void'(cnt.pop_back());
          irqReturn <= 1'b1;
        end
      end
      // offer stays up one edge after the ack, so skip it
      if (gap > 0) begin
        gap = gap - 1;
      end else if (irqReq && acking) begin
        if (wt >= int'(ackDelay)) begin
          irqAck <= 1'b1;
          gap = 2;
          wt = 0;
          cnt.push_back(int'(svcLen));
        end else begin
          wt++;
        end
      end else begin
        wt = 0;
      end
    end
  end
endmodule : iev_core_model

/* File: dv/interrupt_enable_vectoring_tb.sv */
`timescale 1ns/1ps
module interrupt_enable_vectoring_tb;
  logic clk = 1'b0, sys_rst = 1'b1, t0 = 1'b0, t1 = 1'b0, t2 = 1'b0, ser = 1'b0;
  logic pinA = 1'b1, pinB = 1'b1, ce = 1'b1;
  logic we = 1'b0, re = 1'b0, acking = 1'b0, rdHit, run0, run1, irqReq, irqAck, irqReturn, took;
  logic [7:0] addr = 8'h00, wd = 8'h00, svcLen = 8'h03, rdData, en, pri;
  logic [3:0] ackDelay = 4'h0;
  logic [2:0] irqSrc, tookSrc;
  logic [15:0] irqVector, tookVec;
  logic [31:0] seed = 32'h00000015, r;
  logic [5:0] p, act, sel;
  int fails = 0, compares = 0, best;
  int expQ[$];
  always #20 clk = ~clk;
  iev_intc iev_intc_i (.clk(clk), .sys_rst(sys_rst), .ce(ce), .extIrqPinA_n(pinA),
    .extIrqPinB_n(pinB), .timer0Overflow(t0), .timer1Overflow(t1), .timer2Pending(t2),
    .serialPending(ser), .sfrAddr(addr), .sfrWrData(wd), .sfrWrEn(we), .sfrRdEn(re),
    .sfrRdData(rdData), .sfrRdHit(rdHit), .timer0Run(run0), .timer1Run(run1), .irqReq(irqReq),
    .irqSrc(irqSrc), .irqVector(irqVector), .irqAck(irqAck), .irqReturn(irqReturn));
  iev_core_model iev_core_model_i (.clk(clk), .sys_rst(sys_rst), .irqReq(irqReq),
    .irqSrc(irqSrc), .irqVector(irqVector), .acking(acking), .ackDelay(ackDelay),
    .svcLen(svcLen), .irqAck(irqAck), .irqReturn(irqReturn), .took(took),
    .tookSrc(tookSrc), .tookVec(tookVec));
  // ----
  // helpers
  // ----
  task automatic report_and_stop();
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wd = d;
    we = 1'b1;
    cyc(1);
    we = 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic h);
    addr = a;
    re = 1'b1;
    cyc(1);
    re = 1'b0;
    chk(16'(rdData), 16'(d));
    chk(16'(rdHit), 16'(h));
    cyc(1);
  endtask : rd
  task automatic raise(input logic [5:0] s);
    pinA = ~s[0];
    t0 = s[1];
    pinB = ~s[2];
    t1 = s[3];
    if (s[4]) ser = 1'b1;
    if (s[5]) t2 = 1'b1;
    cyc(1);
    t0 = 1'b0;
    t1 = 1'b0;
    cyc(3);
    pinA = 1'b1;
    pinB = 1'b1;
  endtask : raise
  task automatic wait_empty();
    int n;
    n = 0;
    while (expQ.size() > 0 && n < 3000) begin
      cyc(1);
      n++;
    end
    chk(16'(expQ.size()), 16'h0000);
  endtask : wait_empty
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // reference: each taken routine must match the next queued source
  always @(posedge clk) begin : onTake
    int e;
    if (took === 1'b1) begin
      e = (expQ.size() > 0) ? expQ.pop_front() : 7;
      chk(16'(tookSrc), 16'(e));
      chk(tookVec, 16'(e * 8 + 3));
      #1;
      if (e == 4) ser = 1'b0;
      if (e == 5) t2 = 1'b0;
    end
  end
  // about 800 cycles expected; the 10000-cycle limit leaves a generous margin
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
  // ----
  // scenarios
  // ----
  initial begin
    cyc(12);
    sys_rst = 1'b0;
    chk(irqVector, 16'h0003);
    chk(16'(irqReq), 16'h0000);
    rd(8'h88, 8'h00, 1'b1);
    rd(8'ha8, 8'h00, 1'b1);
    rd(8'hb8, 8'h00, 1'b1);
    rd(8'h99, 8'h00, 1'b0);
    // clock enable low: a write must leave no trace
    ce = 1'b0;
    wr(8'ha8, 8'hff);
    ce = 1'b1;
    rd(8'ha8, 8'h00, 1'b1);
    wr(8'ha8, 8'hff);
    rd(8'ha8, 8'hbf, 1'b1);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'h3f, 1'b1);
    wr(8'h88, 8'h55);
    chk(16'(run0), 16'h0001);
    chk(16'(run1), 16'h0001);
    rd(8'h88, 8'h55, 1'b1);
    wr(8'h88, 8'h05);
    wr(8'hb8, 8'h00);
    acking = 1'b1;
    wr(8'ha8, 8'h3f);
    raise(6'h02);
    cyc(6);
    chk(16'(irqReq), 16'h0000);
    expQ.push_back(1);
    wr(8'ha8, 8'h82);
    wait_empty();
    rd(8'h88, 8'h05, 1'b1);
    acking = 1'b0;
    wr(8'h88, 8'h04);
    wr(8'ha8, 8'h81);
    pinA = 1'b0;
    cyc(4);
    chk(16'(irqReq), 16'h0001);
    pinA = 1'b1;
    cyc(4);
    chk(16'(irqReq), 16'h0000);
    wr(8'h88, 8'h05);
    wr(8'ha8, 8'hbf);
    raise(6'h3f);
    cyc(3);
    for (int i = 0; i < 6; i++) expQ.push_back(i);
    acking = 1'b1;
    wait_empty();
    wr(8'hb8, 8'h10);
    ackDelay = 4'h2;
    svcLen = 8'h1e;
    expQ = '{1, 4, 3};
    raise(6'h02);
    cyc(8);
    raise(6'h18);
    wait_empty();
    cyc(40);
    acking = 1'b0;
    repeat (40) begin
      r = xs();
      en = {r[7], 1'b0, r[5:0]};
      pri = {2'b00, r[13:8]};
      p = r[21:16];
      wr(8'ha8, en);
      wr(8'hb8, pri);
      raise(p);
      cyc(1);
      act = en[7] ? (p & en[5:0]) : 6'h00;
      sel = ((act & pri[5:0]) != 6'h00) ? (act & pri[5:0]) : act;
      best = 0;
      for (int k = 5; k >= 0; k--) if (sel[k]) best = k;
      chk(16'(irqReq), 16'(act != 6'h00));
      if (act != 6'h00) chk(16'(irqSrc), 16'(best));
      ser = 1'b0;
      t2 = 1'b0;
      wr(8'h88, 8'h05);
      cyc(2);
    end
    report_and_stop();
  end
endmodule : interrupt_enable_vectoring_tb
